//--- hdl/qtcu_pkg.sv
// shared constants and types of the quad timer counter unit
package qtcu_pkg;

  // timer 0/1 operating modes
  typedef enum logic [1:0] {
    QTCU_M13    = 2'h0,
    QTCU_M16    = 2'h1,
    QTCU_M8R    = 2'h2,
    QTCU_MSPLIT = 2'h3
  } qtcu_mode_e;

  // shared prescale field codes for timers 0/1
  typedef enum logic [1:0] {
    QTCU_PS_DIV12 = 2'h0,
    QTCU_PS_DIV4  = 2'h1,
    QTCU_PS_DIV48 = 2'h2,
    QTCU_PS_EXT8  = 2'h3
  } qtcu_psc_e;

  // timer 2/3 clock sources; code 3 stops the timer
  typedef enum logic [1:0] {
    QTCU_RS_SYS   = 2'h0,
    QTCU_RS_DIV12 = 2'h1,
    QTCU_RS_EXT8  = 2'h2,
    QTCU_RS_OFF   = 2'h3
  } qtcu_rsrc_e;

  // two-wire bus clock source choice
  typedef enum logic [1:0] {
    QTCU_TW_T0   = 2'h0,
    QTCU_TW_T1   = 2'h1,
    QTCU_TW_T2HI = 2'h2,
    QTCU_TW_T2LO = 2'h3
  } qtcu_twsel_e;

  // divider terminal counts (divisor minus one)
  localparam logic [5:0] QTCU_DIV12_LAST = 6'h0b;
  localparam logic [5:0] QTCU_DIV4_LAST = 6'h03;
  localparam logic [5:0] QTCU_DIV48_LAST = 6'h2f;
  localparam logic [5:0] QTCU_PSC_RST = 6'h00;
  localparam logic [3:0] QTCU_SYS12_LAST = 4'hb;
  localparam logic [3:0] QTCU_SYS12_RST = 4'h0;
  localparam logic [2:0] QTCU_EXT8_LAST = 3'h7;
  localparam logic [2:0] QTCU_EXT8_RST = 3'h0;

  // counter limits and reset values
  localparam logic [7:0] QTCU_BYTE_MAX = 8'hff;
  localparam logic [7:0] QTCU_BYTE_ONE = 8'h01;
  localparam logic [7:0] QTCU_BYTE_RST = 8'h00;
  localparam logic [4:0] QTCU_M13_LOW_MAX = 5'h1f;
  localparam logic [15:0] QTCU_WORD_MAX = 16'hffff;
  localparam logic [15:0] QTCU_WORD_ONE = 16'h0001;
  localparam logic [15:0] QTCU_WORD_RST = 16'h0000;

endpackage

//--- hdl/qtcu_sync.sv
// three-stage input synchroniser with agreement-based edge detection
`timescale 1ns/1ns
`default_nettype none
module qtcu_sync
  import qtcu_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // input from outside the clock domain
  input wire logic pin,
  // accepted level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } qtcu_sync_s;

  qtcu_sync_s st_reg;
  qtcu_sync_s st_next;

  // a change is accepted only when stages two and three agree
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.lvl)
    begin
      st_next.lvl = st_reg.s3;
      st_next.rise = st_reg.s3;
      st_next.fall = !st_reg.s3;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign level = st_reg.lvl;
  assign rise = st_reg.rise;
  assign fall = st_reg.fall;

endmodule
`default_nettype wire

//--- hdl/qtcu_reload_timer.sv
// 16-bit or split 8-bit auto-reload timer with capture
`timescale 1ns/1ns
`default_nettype none
module qtcu_reload_timer
  import qtcu_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // configuration
  input wire logic run,
  input wire logic split,
  input wire qtcu_rsrc_e clk_src,
  input wire logic div12_tick,
  input wire logic ext8_tick,
  input wire logic cap_en,
  input wire logic cap_trig,
  input wire logic [15:0] reload_val,
  // direct count write
  input wire logic load,
  input wire logic [15:0] load_val,
  // state and events
  output logic [15:0] count,
  output logic [15:0] cap_val,
  output logic cap_evt,
  output logic ovf_hi,
  output logic ovf_lo
);
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] cap;
    logic capev;
    logic ohi;
    logic olo;
  } qtcu_rt_s;

  qtcu_rt_s st_reg;
  qtcu_rt_s st_next;
  logic tick;

  // clock source selection
  always_comb
  begin
    unique case (clk_src)
      QTCU_RS_SYS: tick = run;
      QTCU_RS_DIV12: tick = run && div12_tick;
      QTCU_RS_EXT8: tick = run && ext8_tick;
      QTCU_RS_OFF: tick = 1'b0;
    endcase
  end

  // counting, reload on the overflow edge, capture
  always_comb
  begin
    st_next = st_reg;
    st_next.ohi = 1'b0;
    st_next.olo = 1'b0;
    st_next.capev = 1'b0;
    if (load)
      {st_next.hi, st_next.lo} = load_val;
    else if (tick && split)
    begin
      // two independent bytes, each with its own reload byte
      st_next.olo = (st_reg.lo == QTCU_BYTE_MAX);
      st_next.lo = st_next.olo ? reload_val[7:0] :
        8'(st_reg.lo + QTCU_BYTE_ONE);
      st_next.ohi = (st_reg.hi == QTCU_BYTE_MAX);
      st_next.hi = st_next.ohi ? reload_val[15:8] :
        8'(st_reg.hi + QTCU_BYTE_ONE);
    end
    else if (tick)
    begin
      st_next.olo = (st_reg.lo == QTCU_BYTE_MAX);
      st_next.ohi = ({st_reg.hi, st_reg.lo} == QTCU_WORD_MAX);
      {st_next.hi, st_next.lo} = st_next.ohi ? reload_val :
        16'({st_reg.hi, st_reg.lo} + QTCU_WORD_ONE);
    end
    if (cap_en && cap_trig)
    begin
      st_next.cap = {st_reg.hi, st_reg.lo};
      st_next.capev = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign count = {st_reg.hi, st_reg.lo};
  assign cap_val = st_reg.cap;
  assign cap_evt = st_reg.capev;
  assign ovf_hi = st_reg.ohi;
  assign ovf_lo = st_reg.olo;

  default clocking rt_cb @(posedge clk);
  endclocking
  default disable iff (!rstn || !ce);

  a_hi_ovf_reload: assert property (
    tick && !load && !split && count == QTCU_WORD_MAX
    |=> ovf_hi && count == $past(reload_val))
    else $error("16-bit overflow did not reload");
  a_split_lo_reload: assert property (
    tick && !load && split && count[7:0] == QTCU_BYTE_MAX
    |=> ovf_lo && count[7:0] == $past(reload_val[7:0]))
    else $error("split low byte did not reload");
  a_capture_latch: assert property (
    cap_en && cap_trig |=> cap_evt && cap_val == $past(count))
    else $error("capture value wrong");
  c_split_hi: cover property (split && ovf_hi);

endmodule
`default_nettype wire

//--- hdl/qtcu_top.sv
// quad timer counter unit: timers 0/1, prescaler, routing, timers 2/3
//
// Overview of operation
// - four independent 16-bit timers: two classic, two auto-reload.
// - timers 0 and 1 offer 13-bit, 16-bit and 8-bit auto-reload modes.
// - split two-byte mode exists on timer 0 only; timer 1 holds there.
// - timers 2 and 3 run 16-bit or as two 8-bit auto-reload bytes.
// - timer 2 captures its count on an external crossbar input.
// - timer 3 captures only on the low-frequency oscillator output.
// - timers 0/1 pick from five sources via select bits and prescale.
// - prescale makes one divided clock; each timer picks it or system_clock.
// - timers 2/3 clock from system_clock, system_clock/12 or external clock/8.
// - counter mode counts each falling edge on the event input.
// - event counting works up to a quarter of the system clock.
// - every timer gives overflow events for interrupts and peripherals.
// - high overflow is full 16-bit or upper byte in split mode.
// - t1 feeds baud; t0/t1/t2 bytes clock bus; t0 clocks array.
// - timer 3 high overflow is the bus clock-low timeout tick.
// - external clock is resynchronised before clocking any timer.
`timescale 1ns/1ns
`default_nettype none
module qtcu_top
  import qtcu_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // pins and foreign-domain inputs
  input wire logic event_input_zero,
  input wire logic event_input_one,
  input wire logic ext_clk_pin,
  input wire logic t2_capture_pin,
  input wire logic lfo_clk,
  // timer 0/1 configuration
  input wire qtcu_psc_e prescale_field,
  input wire logic [1:0] timer_clock_select_bits,
  input wire qtcu_mode_e t0_mode,
  input wire qtcu_mode_e t1_mode,
  input wire logic t0_run,
  input wire logic t1_run,
  input wire logic t0_count_events,
  input wire logic t1_count_events,
  // timer 0/1 count writes
  input wire logic t0_load,
  input wire logic [15:0] t0_load_val,
  input wire logic t1_load,
  input wire logic [15:0] t1_load_val,
  // timer 2 configuration
  input wire logic t2_run,
  input wire logic t2_split,
  input wire qtcu_rsrc_e t2_src,
  input wire logic t2_cap_en,
  input wire logic [15:0] t2_reload,
  input wire logic t2_load,
  input wire logic [15:0] t2_load_val,
  // timer 3 configuration
  input wire logic t3_run,
  input wire logic t3_split,
  input wire qtcu_rsrc_e t3_src,
  input wire logic t3_cap_en,
  input wire logic [15:0] t3_reload,
  input wire logic t3_load,
  input wire logic [15:0] t3_load_val,
  // peripheral routing choice
  input wire qtcu_twsel_e twb_clock_sel,
  // counts and captures
  output logic [15:0] t0_count,
  output logic [15:0] t1_count,
  output logic [15:0] t2_count,
  output logic [15:0] t3_count,
  output logic [15:0] t2_capture,
  output logic [15:0] t3_capture,
  // overflow and capture events, one-cycle pulses
  output logic t0_ovf,
  output logic t0_high_ovf,
  output logic t1_ovf,
  output logic t2_ovf_hi,
  output logic t2_ovf_lo,
  output logic t3_ovf_hi,
  output logic t3_ovf_lo,
  output logic t2_cap_evt,
  output logic t3_cap_evt,
  // feeds to other peripherals
  output logic uart_baud_tick,
  output logic twb_clock_tick,
  output logic twb_low_timeout_tick,
  output logic counter_array_tick
);
  typedef struct packed {
    logic [5:0] psc;
    logic [3:0] d12;
    logic [2:0] e8;
    logic psc_tick;
    logic d12_tick;
    logic e8_tick;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic ovf0;
    logic ovf0h;
    logic ovf1;
  } qtcu_top_s;

  qtcu_top_s st_reg;
  qtcu_top_s st_next;
  logic ev0_fall;
  logic ev1_fall;
  logic ext_rise;
  logic cap2_rise;
  logic lfo_rise;
  logic presc_tick;
  logic t0_clk;
  logic t1_clk;
  logic t0_tick;
  logic t0h_tick;
  logic t1_tick;
  logic [16:0] t0_step;
  logic [16:0] t1_step;

  // terminal count of the shared prescaler
  function automatic logic [5:0] qtcu_psc_last(input qtcu_psc_e f);
    unique case (f)
      QTCU_PS_DIV12: qtcu_psc_last = QTCU_DIV12_LAST;
      QTCU_PS_DIV4: qtcu_psc_last = QTCU_DIV4_LAST;
      QTCU_PS_DIV48: qtcu_psc_last = QTCU_DIV48_LAST;
      QTCU_PS_EXT8: qtcu_psc_last = QTCU_DIV12_LAST;
    endcase
  endfunction

  // one count step of a classic timer: {overflow, high, low}
  function automatic logic [16:0] qtcu_step(
    input qtcu_mode_e m,
    input logic [7:0] tl,
    input logic [7:0] th
  );
    logic [12:0] c13;
    c13 = 13'({th, tl[4:0]} + 13'h0001);
    unique case (m)
      QTCU_M13: // low five bits carry into the high byte
        qtcu_step = {th == QTCU_BYTE_MAX && tl[4:0] == QTCU_M13_LOW_MAX,
          c13[12:5], tl[7:5], c13[4:0]};
      QTCU_M16:
        qtcu_step = {{th, tl} == QTCU_WORD_MAX,
          16'({th, tl} + QTCU_WORD_ONE)};
      QTCU_M8R: // high byte holds the reload value
        qtcu_step = {tl == QTCU_BYTE_MAX, th,
          (tl == QTCU_BYTE_MAX) ? th : 8'(tl + QTCU_BYTE_ONE)};
      QTCU_MSPLIT: // only the low byte; the high byte is done apart
        qtcu_step = {tl == QTCU_BYTE_MAX, th,
          8'(tl + QTCU_BYTE_ONE)};
    endcase
  endfunction

  // pins and foreign clocks each pass a three-stage synchroniser
  qtcu_sync u_sync_ev0 (
    .clk(clk), .rstn(rstn), .ce(ce), .pin(event_input_zero),
    .level(), .rise(), .fall(ev0_fall)
  );
  qtcu_sync u_sync_ev1 (
    .clk(clk), .rstn(rstn), .ce(ce), .pin(event_input_one),
    .level(), .rise(), .fall(ev1_fall)
  );
  qtcu_sync u_sync_ext (
    .clk(clk), .rstn(rstn), .ce(ce), .pin(ext_clk_pin),
    .level(), .rise(ext_rise), .fall()
  );
  qtcu_sync u_sync_cap2 (
    .clk(clk), .rstn(rstn), .ce(ce), .pin(t2_capture_pin),
    .level(), .rise(cap2_rise), .fall()
  );
  qtcu_sync u_sync_lfo (
    .clk(clk), .rstn(rstn), .ce(ce), .pin(lfo_clk),
    .level(), .rise(lfo_rise), .fall()
  );

  // clock source of each classic timer
  always_comb
  begin
    presc_tick = (prescale_field == QTCU_PS_EXT8) ? st_reg.e8_tick :
      st_reg.psc_tick;
    t0_clk = timer_clock_select_bits[0] ? 1'b1 : presc_tick;
    t1_clk = timer_clock_select_bits[1] ? 1'b1 : presc_tick;
    t0_tick = t0_run && (t0_count_events ? ev0_fall : t0_clk);
    t1_tick = t1_run && (t1_count_events ? ev1_fall : t1_clk);
    // in split mode the high byte borrows timer 1's run control
    t0h_tick = t1_run && t0_clk && t0_mode == QTCU_MSPLIT;
    t0_step = qtcu_step(t0_mode, st_reg.tl0, st_reg.th0);
    t1_step = qtcu_step(t1_mode, st_reg.tl1, st_reg.th1);
  end

  // dividers, then the two classic timers
  always_comb
  begin
    st_next = st_reg;
    st_next.psc_tick = 1'b0;
    st_next.d12_tick = 1'b0;
    st_next.e8_tick = 1'b0;
    st_next.ovf0 = 1'b0;
    st_next.ovf0h = 1'b0;
    st_next.ovf1 = 1'b0;
    // free-running system_clock/12 for timers 2 and 3
    if (st_reg.d12 == QTCU_SYS12_LAST)
    begin
      st_next.d12 = QTCU_SYS12_RST;
      st_next.d12_tick = 1'b1;
    end
    else
      st_next.d12 = 4'(st_reg.d12 + 4'h1);
    // >= so that a smaller divisor chosen mid-count wraps at once
    if (st_reg.psc >= qtcu_psc_last(prescale_field))
    begin
      st_next.psc = QTCU_PSC_RST;
      st_next.psc_tick = 1'b1;
    end
    else
      st_next.psc = 6'(st_reg.psc + 6'h01);
    // external clock counted only after resynchronisation
    if (ext_rise)
    begin
      st_next.e8 = 3'(st_reg.e8 + 3'h1);
      st_next.e8_tick = (st_reg.e8 == QTCU_EXT8_LAST);
    end
    // timer 0: a write wins over a count in the same cycle
    if (t0_load)
      {st_next.th0, st_next.tl0} = t0_load_val;
    else
    begin
      if (t0_tick)
        {st_next.ovf0, st_next.th0, st_next.tl0} = t0_step;
      if (t0h_tick)
      begin
        st_next.th0 = 8'(st_reg.th0 + QTCU_BYTE_ONE);
        st_next.ovf0h = (st_reg.th0 == QTCU_BYTE_MAX);
      end
    end
    // timer 1 simply holds when put in the split mode
    if (t1_load)
      {st_next.th1, st_next.tl1} = t1_load_val;
    else if (t1_tick && t1_mode != QTCU_MSPLIT)
      {st_next.ovf1, st_next.th1, st_next.tl1} = t1_step;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  // timer 2 captures on its pin input
  qtcu_reload_timer u_timer2 (
    .clk(clk), .rstn(rstn), .ce(ce), .run(t2_run), .split(t2_split),
    .clk_src(t2_src), .div12_tick(st_reg.d12_tick),
    .ext8_tick(st_reg.e8_tick), .cap_en(t2_cap_en),
    .cap_trig(cap2_rise), .reload_val(t2_reload), .load(t2_load),
    .load_val(t2_load_val), .count(t2_count), .cap_val(t2_capture),
    .cap_evt(t2_cap_evt), .ovf_hi(t2_ovf_hi), .ovf_lo(t2_ovf_lo)
  );
  // timer 3 has no pin capture path at all, only the oscillator
  qtcu_reload_timer u_timer3 (
    .clk(clk), .rstn(rstn), .ce(ce), .run(t3_run), .split(t3_split),
    .clk_src(t3_src), .div12_tick(st_reg.d12_tick),
    .ext8_tick(st_reg.e8_tick), .cap_en(t3_cap_en),
    .cap_trig(lfo_rise), .reload_val(t3_reload), .load(t3_load),
    .load_val(t3_load_val), .count(t3_count), .cap_val(t3_capture),
    .cap_evt(t3_cap_evt), .ovf_hi(t3_ovf_hi), .ovf_lo(t3_ovf_lo)
  );

  // classic timer outputs straight from the state register
  assign t0_count = {st_reg.th0, st_reg.tl0};
  assign t1_count = {st_reg.th1, st_reg.tl1};
  assign t0_ovf = st_reg.ovf0;
  assign t0_high_ovf = st_reg.ovf0h;
  assign t1_ovf = st_reg.ovf1;

  // overflow routing to the other peripherals
  assign uart_baud_tick = st_reg.ovf1;
  assign counter_array_tick = st_reg.ovf0;
  assign twb_low_timeout_tick = t3_ovf_hi;
  always_comb
  begin
    unique case (twb_clock_sel)
      QTCU_TW_T0: twb_clock_tick = st_reg.ovf0;
      QTCU_TW_T1: twb_clock_tick = st_reg.ovf1;
      QTCU_TW_T2HI: twb_clock_tick = t2_ovf_hi;
      QTCU_TW_T2LO: twb_clock_tick = t2_ovf_lo;
    endcase
  end

  // checks run only while the block is clocked and out of reset
  default clocking top_cb @(posedge clk);
  endclocking
  default disable iff (!rstn || !ce);

  a_t0_wrap_16: assert property (
    t0_tick && !t0_load && t0_mode == QTCU_M16 &&
    t0_count == QTCU_WORD_MAX
    |=> t0_ovf && t0_count == QTCU_WORD_RST)
    else $error("timer 0 16-bit wrap wrong");
  a_t0_wrap_13: assert property (
    t0_tick && !t0_load && t0_mode == QTCU_M13 &&
    st_reg.th0 == QTCU_BYTE_MAX && st_reg.tl0[4:0] == QTCU_M13_LOW_MAX
    |=> t0_ovf && st_reg.th0 == QTCU_BYTE_RST && st_reg.tl0[4:0] == 5'h00)
    else $error("timer 0 13-bit wrap wrong");
  a_t1_autoreload: assert property (
    t1_tick && !t1_load && t1_mode == QTCU_M8R &&
    st_reg.tl1 == QTCU_BYTE_MAX
    |=> t1_ovf && st_reg.tl1 == $past(st_reg.th1))
    else $error("timer 1 reload not on overflow edge");
  a_t1_split_hold: assert property (
    t1_mode == QTCU_MSPLIT && !t1_load |=> $stable(t1_count) && !t1_ovf)
    else $error("timer 1 moved in split mode");
  a_event_count: assert property (
    t0_run && t0_count_events && ev0_fall && !t0_load &&
    t0_mode == QTCU_M16 && t0_count != QTCU_WORD_MAX
    |=> t0_count == 16'($past(t0_count) + QTCU_WORD_ONE))
    else $error("event edge not counted");
  a_system_clock_source: assert property (
    t0_run && !t0_count_events && timer_clock_select_bits[0] &&
    !t0_load && t0_mode == QTCU_M16 && t0_count != QTCU_WORD_MAX
    |=> t0_count == 16'($past(t0_count) + QTCU_WORD_ONE))
    else $error("system_clock source did not count");
  a_div12_period: assert property (
    st_reg.d12_tick |-> ##1 (!st_reg.d12_tick)[*8] ##1 !st_reg.d12_tick
    ##1 !st_reg.d12_tick ##1 !st_reg.d12_tick ##1 st_reg.d12_tick)
    else $error("system_clock/12 period wrong");
  a_psc48_tick: assert property (
    st_reg.psc_tick && prescale_field == QTCU_PS_DIV48 &&
    $past(prescale_field) == QTCU_PS_DIV48
    |-> $past(st_reg.psc) >= QTCU_DIV48_LAST)
    else $error("prescale /48 tick early");
  a_ext8_resync: assert property (
    st_reg.e8_tick |-> $past(ext_rise) && $past(st_reg.e8) == QTCU_EXT8_LAST)
    else $error("ext/8 tick without synced edges");

  c_event_ovf: cover property (t0_ovf && t0_count_events);
  c_t3_capture: cover property (t3_cap_evt);
  c_timeout: cover property (twb_low_timeout_tick);
  c_t0_split_hi: cover property (t0_high_ovf);

endmodule
`default_nettype wire

//--- sim/qtcu_far_model.sv
// far-side model: event pin source and free-running external oscillator
`timescale 1ns/1ns
`default_nettype none
module qtcu_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench requests
  input wire logic ext_en,
  input wire logic ev_go,
  input wire logic [3:0] ev_falls,
  // pins toward the unit, busy flag toward the bench
  output logic ev_pin,
  output logic ext_clk,
  output logic ev_busy
);
  logic [4:0] ev_left;
  logic ev_half;
  logic [1:0] ext_div;

  // busy while level changes remain to be made
  assign ev_busy = (ev_left != 5'h00);

  // pin idles high; every level lasts two clocks, the fastest legal rate
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ev_left <= 5'h00;
      ev_half <= 1'h0;
      ev_pin <= 1'h1;
    end
    else if (ev_go)
    begin
      ev_left <= {ev_falls, 1'h0};
      ev_half <= 1'h0;
    end
    else if (ev_busy)
    begin
      ev_half <= ~ev_half;
      if (ev_half)
      begin
        ev_pin <= ~ev_pin;
        ev_left <= ev_left - 5'h01;
      end
    end
  end

  // oscillator with a period of eight clocks; stands still when disabled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_div <= 2'h0;
      ext_clk <= 1'h0;
    end
    else if (ext_en)
    begin
      ext_div <= ext_div + 2'h1;
      if (ext_div == 2'h3)
        ext_clk <= ~ext_clk;
    end
  end
endmodule
`default_nettype wire

//--- sim/qtcu_top_tb.sv
// self-checking bench for the quad timer counter unit
`timescale 1ns/1ns
`default_nettype none
module qtcu_top_tb
  import qtcu_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h1, ce = 1'h1;
  logic event_input_zero, event_input_one, ext_clk_pin;
  logic t2_capture_pin = 1'h0, lfo_clk = 1'h0;
  qtcu_psc_e prescale_field = QTCU_PS_DIV12;
  logic [1:0] timer_clock_select_bits = 2'h0;
  qtcu_mode_e t0_mode = QTCU_M16, t1_mode = QTCU_M16;
  logic t0_run = 1'h0, t1_run = 1'h0;
  logic t0_count_events = 1'h0, t1_count_events = 1'h0;
  logic t0_load = 1'h0, t1_load = 1'h0, t2_load = 1'h0, t3_load = 1'h0;
  logic [15:0] t0_load_val = 16'h0000, t1_load_val = 16'h0000;
  logic [15:0] t2_load_val = 16'h0000, t3_load_val = 16'h0000;
  logic t2_run = 1'h0, t2_split = 1'h0, t2_cap_en = 1'h0;
  logic t3_run = 1'h0, t3_split = 1'h0, t3_cap_en = 1'h0;
  qtcu_rsrc_e t2_src = QTCU_RS_OFF, t3_src = QTCU_RS_OFF;
  logic [15:0] t2_reload = 16'h0000, t3_reload = 16'h0000;
  qtcu_twsel_e twb_clock_sel = QTCU_TW_T0;
  logic [15:0] t0_count, t1_count, t2_count, t3_count;
  logic [15:0] t2_capture, t3_capture;
  logic t0_ovf, t0_high_ovf, t1_ovf, t2_ovf_hi, t2_ovf_lo;
  logic t3_ovf_hi, t3_ovf_lo, t2_cap_evt, t3_cap_evt;
  logic uart_baud_tick, twb_clock_tick, twb_low_timeout_tick;
  logic counter_array_tick;
  logic ext_en = 1'h1, ev_go = 1'h0, ev_pin, ev_busy;
  logic [3:0] ev_falls = 4'h0;
  logic [15:0] e0[4] = '{16'h0040, 16'h00c0, 16'h0010, 16'h000c};
  logic [15:0] e2[4] = '{16'h0300, 16'h0040, 16'h000c, 16'h0000};
  int n_mismatch = 0, cmp_count = 0, k;

  // 20 MHz system clock
  always #25 clk = ~clk;

  // both event pins follow the one far-side source
  assign event_input_zero = ev_pin;
  assign event_input_one = ev_pin;

  qtcu_top DUT (.*);

  // far side: event source and external oscillator
  qtcu_far_model far (.clk(clk), .rstn(rstn), .ext_en(ext_en),
    .ev_go(ev_go), .ev_falls(ev_falls), .ev_pin(ev_pin),
    .ext_clk(ext_clk_pin), .ev_busy(ev_busy));

  // word comparison; flags are widened so one format serves both
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  // counts, verdict and end of run
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a wait that used up its bound ends the run
  task automatic tmo(input logic hit);
    if (hit)
    begin
      n_mismatch++;
      results();
    end
  endtask

  // let n edges pass and their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // strobe the loads picked by the mask; load is taken on the 2nd edge
  task automatic ld(input logic [3:0] m, input logic [15:0] v);
    @(posedge clk);
    {t3_load, t2_load, t1_load, t0_load} <= m;
    {t0_load_val, t1_load_val, t2_load_val, t3_load_val} <= {4{v}};
    @(posedge clk);
    {t3_load, t2_load, t1_load, t0_load} <= 4'h0;
  endtask

  // main sequence
  initial
  begin
    rstn <= 1'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    tick(2);
    chk(t0_count, 16'h0000);
    chk(t2_capture, 16'h0000);
    // timer 0 13-bit: low bits 7:5 kept, bits 4:0 carry into high byte
    @(posedge clk);
    timer_clock_select_bits <= 2'h3;
    t0_mode <= QTCU_M13;
    t0_run <= 1'h1;
    ld(4'h1, 16'h00ff);
    tick(1);
    chk(t0_count, 16'h01e0);
    ld(4'h1, 16'hffff);
    tick(1);
    chk(t0_count, 16'h00e0);
    chk1(t0_ovf, 1'h1);
    // timer 0 16-bit wrap feeds the counter array and the bus clock
    @(posedge clk);
    t0_mode <= QTCU_M16;
    ld(4'h1, 16'hffff);
    tick(1);
    chk(t0_count, 16'h0000);
    chk1(counter_array_tick, 1'h1);
    chk1(twb_clock_tick, 1'h1);
    tick(1);
    chk1(t0_ovf, 1'h0);
    chk(t0_count, 16'h0001);
    // timer 1 byte reload drives the baud tick
    @(posedge clk);
    t1_mode <= QTCU_M8R;
    t1_run <= 1'h1;
    twb_clock_sel <= QTCU_TW_T1;
    ld(4'h2, 16'h80ff);
    tick(1);
    chk(t1_count, 16'h8080);
    chk1(uart_baud_tick, 1'h1);
    chk1(t1_ovf, 1'h1);
    chk1(twb_clock_tick, 1'h1);
    // split: timer 0 high byte runs on t1_run, timer 1 holds
    @(posedge clk);
    t1_mode <= QTCU_MSPLIT;
    t0_mode <= QTCU_MSPLIT;
    t0_run <= 1'h0;
    ld(4'h3, 16'hffff);
    tick(1);
    chk(t0_count, 16'h00ff);
    chk1(t0_high_ovf, 1'h1);
    tick(4);
    chk(t1_count, 16'hffff);
    // timer 2 full reload, then its low byte as bus clock
    @(posedge clk);
    t1_run <= 1'h0;
    t2_src <= QTCU_RS_SYS;
    t2_run <= 1'h1;
    t2_reload <= 16'h1234;
    twb_clock_sel <= QTCU_TW_T2HI;
    ld(4'h4, 16'hffff);
    tick(1);
    chk(t2_count, 16'h1234);
    chk1(t2_ovf_hi, 1'h1);
    chk1(twb_clock_tick, 1'h1);
    @(posedge clk);
    t2_split <= 1'h1;
    twb_clock_sel <= QTCU_TW_T2LO;
    ld(4'h4, 16'h00ff);
    tick(1);
    chk(t2_count, 16'h0134);
    chk1(t2_ovf_lo, 1'h1);
    chk1(twb_clock_tick, 1'h1);
    // timer 3 split: bytes wrap and reload independently
    @(posedge clk);
    t3_src <= QTCU_RS_SYS;
    t3_run <= 1'h1;
    t3_split <= 1'h1;
    t3_reload <= 16'h1020;
    ld(4'h8, 16'hfeff);
    tick(1);
    chk(t3_count, 16'hff20);
    chk1(t3_ovf_lo, 1'h1);
    chk1(t3_ovf_hi, 1'h0);
    tick(1);
    chk(t3_count, 16'h1021);
    chk1(twb_low_timeout_tick, 1'h1);
    // captures with both timers stopped so the latched value is known
    @(posedge clk);
    t2_src <= QTCU_RS_OFF;
    t3_src <= QTCU_RS_OFF;
    t2_cap_en <= 1'h1;
    t3_cap_en <= 1'h1;
    ld(4'hc, 16'h5a5a);
    t2_capture_pin <= 1'h1;
    for (k = 0; k < 12 && t2_cap_evt !== 1'h1; k++)
      tick(1);
    tmo(k == 12);
    chk(t2_capture, 16'h5a5a);
    chk(t3_capture, 16'h0000);
    tick(1);
    chk1(t2_cap_evt, 1'h0);
    @(posedge clk);
    lfo_clk <= 1'h1;
    for (k = 0; k < 12 && t3_cap_evt !== 1'h1; k++)
      tick(1);
    tmo(k == 12);
    chk(t3_capture, 16'h5a5a);
    // five falls on both event pins at a quarter of the clock rate
    @(posedge clk);
    t0_mode <= QTCU_M16;
    t1_mode <= QTCU_M16;
    t0_run <= 1'h1;
    t1_run <= 1'h1;
    t0_count_events <= 1'h1;
    t1_count_events <= 1'h1;
    ev_falls <= 4'h5;
    ld(4'h3, 16'h0000);
    ev_go <= 1'h1;
    @(posedge clk);
    ev_go <= 1'h0;
    tick(1);
    for (k = 0; k < 40 && ev_busy === 1'h1; k++)
      tick(1);
    tmo(k == 40);
    tick(8);
    chk(t0_count, 16'h0005);
    chk(t1_count, 16'h0005);
    // every prescale code and timer 2 source over 768 clocks, a whole number of each period
    @(posedge clk);
    t0_count_events <= 1'h0;
    timer_clock_select_bits <= 2'h0;
    t1_count_events <= 1'h0;
    t2_split <= 1'h0;
    t3_run <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      prescale_field <= qtcu_psc_e'(i);
      t2_src <= qtcu_rsrc_e'(i);
      tick(100);
      ld(4'h7, 16'h0000);
      tick(768);
      chk(t0_count, e0[i]);
      chk(t1_count, e0[i]);
      chk(t2_count, e2[i]);
    end
    // ce low freezes all state, so a load made then is lost
    @(posedge clk);
    t0_run <= 1'h0;
    ld(4'h1, 16'h1234);
    ce <= 1'h0;
    ld(4'h1, 16'h4321);
    tick(1);
    chk(t0_count, 16'h1234);
    results();
  end
endmodule
`default_nettype wire
